// >>> hw/gain_port_consts.svh
// Constants for the serial gain control port: widths, reset values, timing.
// Assumes inclusion by bare name from the package and the design modules.
// How it works
// - Strobe rising edge copies shift register to latch
// - Strobe high blocks serial bits into register
// - Strobe falling holds latch, enables shifting
// - Eight-bit word, most significant bit first
// - Serial clock rise captures data into master
// - Serial clock fall moves master into slave
// - Sleep low powers down, output high impedance
// - Transmit gate low blocks forward transmission
// - Latch starts at gain code one
// - Each code step changes gain one dB
`ifndef GAIN_PORT_CONSTS_SVH
`define GAIN_PORT_CONSTS_SVH

`define GAIN_WORD_BITS     8
`define GAIN_RESET_CODE    8'h01
`define GAIN_MIN_DB        (-28)
`define GAIN_MAX_DB        31
`define GAIN_STEP_DB       1
`define SYS_CLK_PERIOD_NS  8
`define SCLK_MIN_PERIOD_NS 32
`define SCLK_MIN_PERIOD_CYC ((`SCLK_MIN_PERIOD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// >>> hw/gain_port_pkg.sv
// Types shared by the serial gain control port modules.
// Assumes gain_port_consts.svh is on the include path.
`include "gain_port_consts.svh"

package gain_port_pkg;
	typedef logic [`GAIN_WORD_BITS-1:0] gain_word_t;
	typedef enum logic [1:0] {
		PWR_SLEEP,
		PWR_IDLE,
		PWR_FORWARD
	} power_mode_e;
endpackage

// >>> hw/edge_detect.sv
// Rising and falling edge detector for a level sampled on sys_clk.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none

module edge_detect #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      rise,
	output logic      fall
);
	logic last_q;
	logic last_d;

	always_comb begin
		last_d = level;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= RESET_LEVEL;
		end else begin
			last_q <= last_d;
		end
	end

	assign rise = level & ~last_q;
	assign fall = ~level & last_q;
endmodule

`default_nettype wire

// >>> hw/serial_gain_control_port.sv
// Serial gain control port: three-wire gain loading plus power and gate control.
// Assumes all pins are synchronous to sys_clk and serial clock is slow to it.
`timescale 1ns/10ps
`default_nettype none

`include "gain_port_consts.svh"

module serial_gain_control_port #(
	parameter int WORD_BITS = `GAIN_WORD_BITS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 serial_clk,
	input  wire logic                 gain_load_strobe_n,
	input  wire logic                 serial_gain_in,
	input  wire logic                 transmit_gate,
	input  wire logic                 sleep_n,
	output logic [WORD_BITS-1:0]      gain_code,
	output logic                      gain_update,
	output logic                      forward_enable,
	output logic                      core_powered,
	output logic                      output_drive_en,
	output logic [WORD_BITS-1:0]      shift_image
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One shift step: older bits move up, the new bit enters at the bottom.
	// Shared by the slave stage and the late-fall path into the latch, so
	// both always agree on the bit order.
	function automatic logic [WORD_BITS-1:0] shift_in(
		input logic [WORD_BITS-1:0] word,
		input logic                 new_bit
	);
		shift_in = {word[WORD_BITS-2:0], new_bit};
	endfunction

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic sclk_rise;
	logic sclk_fall;
	logic strobe_rise;
	logic strobe_fall;

	edge_detect #(.RESET_LEVEL(1'b0)) u_sclk_edge (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.level   (serial_clk),
		.rise    (sclk_rise),
		.fall    (sclk_fall)
	);

	// Strobe idles high, so reset level high avoids a false load
	edge_detect #(.RESET_LEVEL(1'b1)) u_strobe_edge (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.level   (gain_load_strobe_n),
		.rise    (strobe_rise),
		.fall    (strobe_fall)
	);

	// ------------------------------------------------------------
	// Master-slave shift register and gain latch
	// ------------------------------------------------------------
	logic                 shift_en_q;
	logic                 shift_en_d;
	logic                 master_q;
	logic                 master_d;
	logic [WORD_BITS-1:0] slave_q;
	logic [WORD_BITS-1:0] slave_d;
	logic [WORD_BITS-1:0] latch_q;
	logic [WORD_BITS-1:0] latch_d;
	logic                 update_q;
	logic                 update_d;

	always_comb begin
		shift_en_d = shift_en_q;
		master_d   = master_q;
		slave_d    = slave_q;
		latch_d    = latch_q;
		update_d   = 1'b0;
		if (strobe_fall) begin
			shift_en_d = 1'b1;
		end
		if (strobe_rise) begin
			shift_en_d = 1'b0;
			// A fall coinciding with the strobe rise still completes its bit
			if (sclk_fall && shift_en_q) begin
				latch_d = shift_in(slave_q, master_q);
			end else begin
				latch_d = slave_q;
			end
			update_d = 1'b1;
		end
		// Data bit must be valid on the sample edge of serial clock
		if (shift_en_q && !gain_load_strobe_n && sclk_rise) begin
			master_d = serial_gain_in;
		end
		if (shift_en_q && sclk_fall) begin
			// Oldest bit falls off the top, so the last eight survive
			slave_d = shift_in(slave_q, master_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_en_q <= 1'b0;
			master_q   <= 1'b0;
			slave_q    <= '0;
			latch_q    <= WORD_BITS'(`GAIN_RESET_CODE);
			update_q   <= 1'b0;
		end else begin
			shift_en_q <= shift_en_d;
			master_q   <= master_d;
			slave_q    <= slave_d;
			latch_q    <= latch_d;
			update_q   <= update_d;
		end
	end

	// ------------------------------------------------------------
	// Power and transmit gate
	// ------------------------------------------------------------
	// Mode is decoded from the pins and its three views are registered
	// directly, so every control output leaves from a flip-flop with the
	// same single cycle of lag as before.
	gain_port_pkg::power_mode_e mode_d;
	logic                       forward_q;
	logic                       forward_d;
	logic                       powered_q;
	logic                       powered_d;
	logic                       drive_q;
	logic                       drive_d;

	always_comb begin
		case ({sleep_n, transmit_gate})
			2'b00, 2'b01: mode_d = gain_port_pkg::PWR_SLEEP;
			2'b10:        mode_d = gain_port_pkg::PWR_IDLE;
			2'b11:        mode_d = gain_port_pkg::PWR_FORWARD;
			default:      mode_d = gain_port_pkg::PWR_SLEEP;
		endcase
		forward_d = (mode_d == gain_port_pkg::PWR_FORWARD);
		powered_d = (mode_d != gain_port_pkg::PWR_SLEEP);
		// Output stays driven in idle to hold the matched output impedance
		drive_d   = (mode_d != gain_port_pkg::PWR_SLEEP);
	end

	// Reset comes up asleep: nothing forwards before software has spoken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			forward_q <= 1'b0;
			powered_q <= 1'b0;
			drive_q   <= 1'b0;
		end else begin
			forward_q <= forward_d;
			powered_q <= powered_d;
			drive_q   <= drive_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Code maps linearly to dB in the analog core, one dB per step
	assign gain_code       = latch_q;
	assign gain_update     = update_q;
	assign shift_image     = slave_q;
	assign forward_enable  = forward_q;
	assign core_powered    = powered_q;
	assign output_drive_en = drive_q;
endmodule

`default_nettype wire

// >>> sim/gain_port_props.sv
// Checker for the gain port outputs.
// Assumes a bind onto serial_gain_control_port.
`timescale 1ns/10ps
`default_nettype none
module gain_port_props #(parameter int WORD_BITS = 8) (
	input wire logic                 sys_clk,
	input wire logic                 rst_n,
	input wire logic                 serial_clk,
	input wire logic                 gain_load_strobe_n,
	input wire logic                 serial_gain_in,
	input wire logic                 transmit_gate,
	input wire logic                 sleep_n,
	input wire logic [WORD_BITS-1:0] gain_code,
	input wire logic                 gain_update,
	input wire logic                 forward_enable,
	input wire logic                 core_powered,
	input wire logic                 output_drive_en,
	input wire logic [WORD_BITS-1:0] shift_image
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence load_open;
		(!gain_load_strobe_n)[*3] ##0 $fell(serial_clk);
	endsequence
	a_latch_on_rise: assert property (
		$rose(gain_load_strobe_n) |=> gain_update && gain_code == $past(shift_image))
		else $error("latch not loaded");
	a_update_pulse: assert property (gain_update |=> !gain_update)
		else $error("update too long");
	a_code_hold: assert property ($changed(gain_code) |-> gain_update)
		else $error("gain changed outside load");
	a_stop_high: assert property (gain_load_strobe_n[*3] |-> $stable(shift_image))
		else $error("shift while strobe high");
	a_shift_msb: assert property (
		load_open |=> shift_image == {$past(shift_image[WORD_BITS-2:0]), $past(serial_gain_in)})
		else $error("shift wrong");
	a_sleep_off: assert property (!sleep_n |=> !core_powered && !output_drive_en)
		else $error("not asleep");
	a_awake_mode: assert property (
		sleep_n |=> core_powered && output_drive_en && forward_enable == $past(transmit_gate))
		else $error("awake mode wrong");
	a_gate_block: assert property (!transmit_gate |=> !forward_enable)
		else $error("forward while gated");
endmodule
bind serial_gain_control_port gain_port_props #(.WORD_BITS(WORD_BITS)) u_gain_port_props (.*);
`default_nettype wire

// >>> sim/host_model.sv
// Host side of the three-wire gain port.
// Assumes the bench calls its tasks at falling sys_clk edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic sys_clk,
	output logic      serial_clk,
	output logic      gain_load_strobe_n,
	output logic      serial_gain_in
);
	initial {serial_clk, gain_load_strobe_n, serial_gain_in} = 3'h2;
	task automatic send(input logic [15:0] w, input int n);
		// Strobe stays high at least two cycles between words
		repeat (2) @(negedge sys_clk);
		gain_load_strobe_n = 0;
		repeat (2) @(negedge sys_clk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_gain_in = w[i];
			repeat (2) @(negedge sys_clk);
			serial_clk = 1;
			repeat (2) @(negedge sys_clk);
			serial_clk = 0;
			repeat (2) @(negedge sys_clk);
		end
		gain_load_strobe_n = 1;
		// Released line shows the inverse, never the last bit
		serial_gain_in = ~serial_gain_in;
	endtask
	task automatic stray();
		repeat (4) begin
			serial_gain_in = ~serial_gain_in;
			serial_clk = ~serial_clk;
			repeat (2) @(negedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/serial_gain_control_port_tb.sv
// Bench for the serial gain control port.
// Assumes the host model drives the three serial pins.
`timescale 1ns/10ps
`default_nettype none
module serial_gain_control_port_tb;
	logic       sys_clk, rst_n, serial_clk, gain_load_strobe_n, serial_gain_in;
	logic       transmit_gate, sleep_n, gain_update, forward_enable;
	logic       core_powered, output_drive_en;
	logic [7:0] gain_code, shift_image;
	int         err_count = 0;
	int         checked = 0;
	serial_gain_control_port u_serial_gain_control_port (.*);
	host_model u_host_model (.*);
	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic load(input logic [15:0] w, input int n, input logic [7:0] e);
		int k;
		u_host_model.send(w, n);
		for (k = 0; k < 10 && gain_update !== 1'b1; k++)
			@(negedge sys_clk);
		if (k == 10) begin
			err_count++;
			end_sim();
		end
		cmp("gain_code", e, gain_code);
	endtask
	task automatic t_load();
		load(16'h00a5, 8, 8'ha5);
		load(16'h003c, 8, 8'h3c);
		u_host_model.stray();
		cmp("gain_code", 8'h3c, gain_code);
		cmp("shift_image", 8'h3c, shift_image);
		load(16'h05c3, 12, 8'hc3);
		$display("t_load done");
	endtask
	task automatic t_reset_mid();
		@(negedge sys_clk);
		rst_n = 0;
		repeat (2) @(negedge sys_clk);
		cmp("gain_code", 8'h01, gain_code);
		cmp("shift_image", 8'h00, shift_image);
		rst_n = 1;
		repeat (3) @(negedge sys_clk);
		load(16'h0081, 8, 8'h81);
		$display("t_reset_mid done");
	endtask
	task automatic t_modes();
		for (int i = 0; i < 4; i++) begin
			{sleep_n, transmit_gate} = i[1:0];
			repeat (2) @(negedge sys_clk);
			cmp("modes", {5'h0, i[1], i[1], i == 3},
				{5'h0, core_powered, output_drive_en, forward_enable});
		end
		$display("t_modes done");
	endtask
	initial begin
		rst_n = 0;
		transmit_gate = 0;
		sleep_n = 1;
		repeat (2) @(negedge sys_clk);
		rst_n = 1;
		repeat (3) @(negedge sys_clk);
		cmp("gain_code", 8'h01, gain_code);
		$display("t_reset done");
		t_load();
		t_reset_mid();
		t_modes();
		end_sim();
	end
endmodule
`default_nettype wire
